// ---- dv/sbba_host_model.sv ----
// Purpose: memory controller model driving command pins and write beats
// Assumes: pins change at the falling edge of the link clock
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module sbba_host_model (
  input  wire logic        dram_clk,          // link clock
  output logic             cs_n,              // chip select, low
  output logic             act_n,             // activate, low
  output logic             ras_n,             // command bit
  output logic             cas_n,             // command bit
  output logic             we_n,              // command bit
  output logic [1:0]       group_select_bits, // bank group
  output logic [1:0]       bank_select_bits,  // bank in group
  output logic [15:0]      addr,              // row or column
  output logic             data_strobe,       // write pair valid
  output logic [7:0]       dq_rise,           // first beat
  output logic [7:0]       dq_fall            // second beat
);
  // idle pins at time zero
  initial
  begin
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
    {group_select_bits, bank_select_bits, addr} = 20'h0;
    {data_strobe, dq_rise, dq_fall} = 17'h0;
  end
  // one command, then for writes the beat pairs, two beats a clock
  task automatic send(input sbba_pkg::sbba_op_t op, input logic [3:0] gb,
                      input logic [15:0] a, input logic [63:0] d,
                      input int pairs);
    @(negedge dram_clk);
    cs_n = 1'b0;
    case (op)
      sbba_pkg::SBBA_OP_ACT: {act_n, ras_n, cas_n, we_n} = 4'h7;
      sbba_pkg::SBBA_OP_RD:  {act_n, ras_n, cas_n, we_n} = 4'hd;
      sbba_pkg::SBBA_OP_WR:  {act_n, ras_n, cas_n, we_n} = 4'hc;
      default:               {act_n, ras_n, cas_n, we_n} = 4'ha;
    endcase
    {group_select_bits, bank_select_bits, addr} = {gb, a};
    @(negedge dram_clk);
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
    {group_select_bits, bank_select_bits, addr} = ~{gb, a};
    if (op == sbba_pkg::SBBA_OP_WR)
    begin
      for (int i = 0; i < pairs; i++)
      begin
        @(negedge dram_clk);
        data_strobe = 1'b1;
        {dq_fall, dq_rise} = d[16*(i%4) +: 16];
      end
      @(negedge dram_clk);
      data_strobe = 1'b0;
      {dq_fall, dq_rise} = ~{dq_fall, dq_rise};
    end
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Purpose: directed tests of command decode, bursts and bank tracking
// Assumes: link clock 12 ns, core clock 5 ns, straps held while idle
// Notes:   bank 6 is activated once before all its accesses; the read after the auto close is refused
`timescale 1ns/1ps
module tb_top;
  localparam logic [63:0] W = 64'h0f1e2d3c4b5aa55a;
  localparam logic [63:0] V = 64'h8877665544332211;
  logic ref_clk = 1'b0, dram_clk = 1'b0, reset_n = 1'b0, hold_in = 1'b0;
  logic wide_mode = 1'b0, otf_enable = 1'b0, fixed_chop = 1'b0;
  logic crc_enable = 1'b0, dropped = 1'b0;
  logic cs_n, act_n, ras_n, cas_n, we_n, data_strobe;
  logic [1:0] group_select_bits, bank_select_bits;
  logic [15:0] addr, open_banks;
  logic [7:0] dq_rise, dq_fall;
  logic link_ready, cmd_dropped, access_error, wr_done, rd_valid;
  logic [63:0] rd_word;
  logic [3:0] rd_bank;
  logic [9:0] rd_col;
  int fail_count = 0, compares = 0;
  // both clocks, unrelated in phase
  initial forever #2.5 ref_clk = ~ref_clk;
  initial
  begin
    #1.7;
    forever #6 dram_clk = ~dram_clk;
  end
  // remember any lost command
  always @(posedge dram_clk) if (cmd_dropped === 1'b1) dropped <= 1'b1;
  sbba_host_model sbba_host_model_inst (.*);
  sbba_top sbba_top_inst (.*);
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait for a core pulse: 0 read, 1 write, 2 error
  task automatic wait_for(input int sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 200 && !hit; i++)
    begin
      @(negedge ref_clk);
      hit = (sel == 0) ? rd_valid === 1'b1 :
            (sel == 1) ? wr_done === 1'b1 : access_error === 1'b1;
    end
    check("pulse", 64'(hit), 64'h1);
  endtask
  task automatic settle();
    repeat (60) @(negedge ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [63:0] exp);
    sbba_host_model_inst.send(sbba_pkg::SBBA_OP_RD, 4'h6, a, 64'h0, 0);
    wait_for(0);
    check("rd_word", rd_word, exp);
    check("rd_bank", 64'(rd_bank), 64'h6);
    check("rd_col", 64'(rd_col), 64'(a[9:0]));
  endtask
  task automatic reset_dut();
    reset_n = 1'b0;
    repeat (3) @(negedge dram_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge dram_clk);
  endtask
  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    reset_dut();
    check("open_banks", 64'(open_banks), 64'h0);
    sbba_host_model_inst.send(sbba_pkg::SBBA_OP_ACT, 4'h6, 16'h1234, 0, 0);
    settle();
    check("open_banks", 64'(open_banks), 64'h40);
    sbba_host_model_inst.send(sbba_pkg::SBBA_OP_WR, 4'h6, 16'h0, W, 4);
    wait_for(1);
    rd(16'h0000, W);
    rd(16'h0003, {W[23:0], W[63:24]});
    $display("test burst done");
    @(negedge ref_clk) otf_enable = 1'b1;
    settle();
    rd(16'h0000, {32'h0, W[31:0]});
    rd(16'h1000, W);
    sbba_host_model_inst.send(sbba_pkg::SBBA_OP_WR, 4'h6, 16'h0, V, 2);
    wait_for(1);
    rd(16'h1000, {W[63:32], V[31:0]});
    @(negedge ref_clk) {otf_enable, fixed_chop} = 2'h1;
    settle();
    rd(16'h1000, {32'h0, V[31:0]});
    @(negedge ref_clk) {otf_enable, fixed_chop, crc_enable} = 3'h1;
    settle();
    sbba_host_model_inst.send(sbba_pkg::SBBA_OP_WR, 4'h6, 16'h0, V, 5);
    wait_for(1);
    rd(16'h0400, V);
    settle();
    check("open_banks", 64'(open_banks), 64'h0);
    sbba_host_model_inst.send(sbba_pkg::SBBA_OP_RD, 4'h6, 16'h0, 0, 0);
    wait_for(2);
    $display("test options done");
    @(negedge ref_clk) {wide_mode, crc_enable} = 2'h2;
    settle();
    sbba_host_model_inst.send(sbba_pkg::SBBA_OP_ACT, 4'hd, 16'h0, 0, 0);
    settle();
    check("open_banks", 64'(open_banks), 64'h20);
    @(negedge ref_clk) {wide_mode, hold_in} = 2'h1;
    settle();
    for (int i = 0; i < 18; i++)
      sbba_host_model_inst.send(sbba_pkg::SBBA_OP_ACT, 4'h0, 16'h0, 0, 0);
    repeat (4) @(negedge dram_clk);
    check("link_ready", 64'(link_ready), 64'h0);
    check("dropped", 64'(dropped), 64'h1);
    @(negedge ref_clk) hold_in = 1'b0;
    settle();
    check("link_ready", 64'(link_ready), 64'h1);
    check("open_banks", 64'(open_banks), 64'h21);
    $display("test fifo done");
    reset_dut();
    check("open_banks", 64'(open_banks), 64'h0);
    $display("test reset done");
    wrap_up();
  end
endmodule

// ---- src/sbba_beat_collect.sv ----
// Purpose: gathers write beats, two per link clock, into one core word
// Assumes: strobe marks a clock carrying a rising and a falling beat
// Notes:   pairs beyond keep (checksum beats) are counted, not stored
`timescale 1ns/1ps
module sbba_beat_collect (
  input  wire logic                         clk,     // link clock
  input  wire logic                         rst_n,   // link reset
  input  wire logic                         start,   // burst begins
  input  wire logic [sbba_pkg::PCNT_W-1:0]  keep,    // data pairs
  input  wire logic [sbba_pkg::PCNT_W-1:0]  need,    // all pairs
  input  wire logic                         strobe,  // pair present
  input  wire logic [sbba_pkg::WORD_W-1:0]  dq_rise, // first beat
  input  wire logic [sbba_pkg::WORD_W-1:0]  dq_fall, // second beat
  output logic                              busy,    // burst running
  output logic                              done,    // word complete
  output logic [sbba_pkg::CORE_W-1:0]       word     // gathered word
);
  typedef struct packed {
    logic                        active;
    logic [sbba_pkg::PCNT_W-1:0] pcnt;
    logic [sbba_pkg::PCNT_W-1:0] keep;
    logic [sbba_pkg::PCNT_W-1:0] need;
    logic                        done;
    logic [sbba_pkg::CORE_W-1:0] word;
  } sbba_col_t;
  sbba_col_t s_r, s_nxt;

  assign busy = s_r.active;
  assign done = s_r.done;
  assign word = s_r.word;

  // pair counting and placement, beat 0 in the low byte
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.active)
    begin
      if (start)
      begin
        s_nxt.active = 1'b1;
        s_nxt.pcnt   = '0;
        s_nxt.keep   = keep;
        s_nxt.need   = need;
        s_nxt.word   = '0;
      end
    end
    else if (strobe)
    begin
      if (s_r.pcnt < s_r.keep)
        s_nxt.word[s_r.pcnt[1:0]*sbba_pkg::PAIR_W +: sbba_pkg::PAIR_W] =
          {dq_fall, dq_rise};
      s_nxt.pcnt = s_r.pcnt + 1'b1;
      if (s_nxt.pcnt == s_r.need)
      begin
        s_nxt.active = 1'b0;
        s_nxt.done   = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// ---- src/sbba_fifo.sv ----
// Purpose: dual-clock FIFO, gray-coded pointers
// Assumes: D is a power of two
// Notes:   in_ready low means full; out_valid low means empty
`timescale 1ns/1ps
module sbba_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         w_clk,     // filling clock
  input  wire logic         w_rst_n,   // filling reset
  input  wire logic         in_valid,  // entry offered
  input  wire logic [W-1:0] in_data,   // entry
  output logic              in_ready,  // not full
  input  wire logic         r_clk,     // draining clock
  input  wire logic         r_rst_n,   // draining reset
  output logic              out_valid, // not empty
  output logic [W-1:0]      out_data,  // head entry
  input  wire logic         out_ready  // head taken
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] s1;
    logic [AW:0] s2;
  } sbba_ptr_t;
  sbba_ptr_t    w_r, w_nxt, r_r, r_nxt;
  logic [W-1:0] mem [D];

  // flags from own pointer and synced far pointer
  assign in_ready  = (w_r.gray != {~w_r.s2[AW:AW-1], w_r.s2[AW-2:0]});
  assign out_valid = (r_r.gray != r_r.s2);
  assign out_data  = mem[r_r.bin[AW-1:0]];

  // pointer advance and gray sync chains
  always_comb
  begin
    w_nxt      = w_r;
    w_nxt.s1   = r_r.gray;
    w_nxt.s2   = w_r.s1;
    if (in_valid && in_ready)
    begin
      w_nxt.bin  = w_r.bin + 1'b1;
      w_nxt.gray = w_nxt.bin ^ (w_nxt.bin >> 1);
    end
    r_nxt      = r_r;
    r_nxt.s1   = w_r.gray;
    r_nxt.s2   = r_r.s1;
    if (out_valid && out_ready)
    begin
      r_nxt.bin  = r_r.bin + 1'b1;
      r_nxt.gray = r_nxt.bin ^ (r_nxt.bin >> 1);
    end
  end

  // filling side
  always_ff @(posedge w_clk or negedge w_rst_n)
  begin
    if (!w_rst_n)
      w_r <= '0;
    else
      w_r <= w_nxt;
  end

  // storage, written on the filling clock only
  always_ff @(posedge w_clk)
  begin
    if (in_valid && in_ready)
      mem[w_r.bin[AW-1:0]] <= in_data;
  end

  // draining side
  always_ff @(posedge r_clk or negedge r_rst_n)
  begin
    if (!r_rst_n)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end
endmodule

// ---- src/sbba_pkg.sv ----
// Purpose: shared constants and types for the bank/burst addressing block
// Assumes: n = 8 bits per beat, 8n prefetch, 16 bank slots
// Notes:   the command word carries write data through the link FIFO
package sbba_pkg;
  localparam int WORD_W     = 8;            // n, bits per beat
  localparam int PREFETCH   = 8;            // beats per core transfer
  localparam int CORE_W     = WORD_W * PREFETCH;
  localparam int PAIR_W     = 2 * WORD_W;   // two beats per clock
  localparam int ROW_W      = 16;
  localparam int COL_W      = 10;
  localparam int BANKS      = 16;
  localparam int BIDX_W     = 4;
  localparam int SLOT_W     = 3;            // log2 of bursts kept per bank, 8 per bank
  localparam int FIFO_DEPTH = 16;
  localparam int PCNT_W     = 3;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int CHOP_SEL_BIT   = 12;
  localparam int SLOT_LSB   = 3;            // column bits inside a burst
  localparam logic [PCNT_W-1:0] PAIRS_FULL = 3'h4;
  localparam logic [PCNT_W-1:0] PAIRS_CHOP = 3'h2;
  localparam logic [PCNT_W-1:0] PAIRS_CRC  = 3'h1;
  localparam int CFG_WIDE = 0;
  localparam int CFG_OTF  = 1;
  localparam int CFG_FIX4 = 2;
  localparam int CFG_CRC  = 3;
  localparam int CFG_W    = 4;

  typedef enum logic [1:0] {
    SBBA_OP_ACT,
    SBBA_OP_RD,
    SBBA_OP_WR,
    SBBA_OP_PRE
  } sbba_op_t;

  typedef struct packed {
    sbba_op_t          op;
    logic [1:0]        group;
    logic [1:0]        bank;
    logic [ROW_W-1:0]  addr;
    logic              auto_close;
    logic              chop;
    logic [CORE_W-1:0] data;
  } sbba_cmd_t;

  localparam int CMD_W = $bits(sbba_cmd_t);
endpackage

// ---- src/sbba_top.sv ----
// Purpose: command decode, bank/row tracking and burst storage of a DRAM
// Assumes: command pins and write beats are timed by dram_clk
// Notes:   decoded commands cross to ref_clk through a 16-entry FIFO
`timescale 1ns/1ps

module sbba_top (
  input  wire logic        ref_clk,           // core clock
  input  wire logic        reset_n,           // async reset, low
  input  wire logic        dram_clk,          // link clock
  input  wire logic        cs_n,              // chip select, low
  input  wire logic        act_n,             // activate, low
  input  wire logic        ras_n,             // command bit
  input  wire logic        cas_n,             // command bit
  input  wire logic        we_n,              // command bit
  input  wire logic [1:0]  group_select_bits, // bank group
  input  wire logic [1:0]  bank_select_bits,  // bank in group
  input  wire logic [15:0] addr,              // row or column
  input  wire logic        data_strobe,       // write pair valid
  input  wire logic [7:0]  dq_rise,           // write beat, rise
  input  wire logic [7:0]  dq_fall,           // write beat, fall
  input  wire logic        wide_mode,         // x16 organisation
  input  wire logic        otf_enable,        // chop on the fly
  input  wire logic        fixed_chop,        // fixed chop four
  input  wire logic        crc_enable,        // write checksum
  input  wire logic        hold_in,           // stall core side
  output logic             link_ready,        // FIFO has room
  output logic             cmd_dropped,       // command lost
  output logic [15:0]      open_banks,        // open row flags
  output logic             access_error,      // access unopened
  output logic             wr_done,           // write stored
  output logic             rd_valid,          // read word out
  output logic [63:0]      rd_word,           // read data
  output logic [3:0]       rd_bank,           // read bank
  output logic [9:0]       rd_col             // read start col
);
  typedef struct packed {
    logic [1:0]                  rst;
    logic [sbba_pkg::CFG_W-1:0]  cfg1;
    logic [sbba_pkg::CFG_W-1:0]  cfg2;
    logic                        cs_n;
    logic                        act_n;
    logic                        ras_n;
    logic                        cas_n;
    logic                        we_n;
    logic [1:0]                  bg;
    logic [1:0]                  ba;
    logic [sbba_pkg::ROW_W-1:0]  a;
    sbba_pkg::sbba_cmd_t         pend;
    logic                        push;
    sbba_pkg::sbba_cmd_t         push_cmd;
    logic                        ready;
    logic                        dropped;
  } sbba_link_t;

  typedef struct packed {
    logic [sbba_pkg::BANKS-1:0]                     open;
    logic [sbba_pkg::BANKS-1:0][sbba_pkg::ROW_W-1:0] row;
    logic                                           err;
    logic                                           wr_done;
    logic                                           rd_valid;
    logic [sbba_pkg::CORE_W-1:0]                    rd_word;
    logic [sbba_pkg::BIDX_W-1:0]                    rd_bank;
    logic [sbba_pkg::COL_W-1:0]                     rd_col;
  } sbba_core_t;

  sbba_link_t          l_r, l_nxt;
  sbba_core_t          c_r, c_nxt;
  logic [1:0]          crst_r;
  logic                crst_n;
  logic                lrst_n;
  logic                f_in_ready;
  logic                f_out_valid;
  logic [sbba_pkg::CMD_W-1:0] f_out_data;
  sbba_pkg::sbba_cmd_t cmd;
  logic                take;
  logic                d_act, d_rd, d_wr, d_pre;
  logic                w_chop;
  logic                col_start, col_busy, col_done;
  logic [sbba_pkg::PCNT_W-1:0] col_keep, col_need;
  logic [sbba_pkg::CORE_W-1:0] col_word;
  logic [sbba_pkg::BIDX_W-1:0] idx;
  logic [sbba_pkg::BIDX_W+sbba_pkg::SLOT_W-1:0] slot;
  logic [2:0]          scol;
  logic                mem_we;
  logic [sbba_pkg::CORE_W-1:0] mem_wdata, mem_rdata;
  logic [sbba_pkg::CORE_W-1:0] mem [sbba_pkg::BANKS << sbba_pkg::SLOT_W];

  // rotate a core word by whole beats, start column first
  function automatic logic [sbba_pkg::CORE_W-1:0] rot_l(
    input logic [sbba_pkg::CORE_W-1:0] w,
    input logic [2:0]                  k
  );
    logic [2*sbba_pkg::CORE_W-1:0] d;
    d = {w, w} << (k * sbba_pkg::WORD_W);
    return d[2*sbba_pkg::CORE_W-1 -: sbba_pkg::CORE_W];
  endfunction

  // core reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      crst_r <= 2'h0;
    else
      crst_r <= {crst_r[0], 1'b1};
  end
  assign crst_n = crst_r[1];
  assign lrst_n = l_r.rst[1];

  // link side: pin capture, decode, write collection, FIFO push
  assign d_act = !l_r.cs_n && !l_r.act_n;
  assign d_rd  = !l_r.cs_n && l_r.act_n && l_r.ras_n && !l_r.cas_n
                 && l_r.we_n;
  assign d_wr  = !l_r.cs_n && l_r.act_n && l_r.ras_n && !l_r.cas_n
                 && !l_r.we_n;
  assign d_pre = !l_r.cs_n && l_r.act_n && !l_r.ras_n && l_r.cas_n
                 && !l_r.we_n;
  // low on the select bit means the chopped four-beat burst
  assign w_chop = l_r.cfg2[sbba_pkg::CFG_OTF] ?
                  !l_r.a[sbba_pkg::CHOP_SEL_BIT] :
                  l_r.cfg2[sbba_pkg::CFG_FIX4];
  assign col_start = d_wr && !col_busy && lrst_n;
  assign col_keep  = w_chop ? sbba_pkg::PAIRS_CHOP
                            : sbba_pkg::PAIRS_FULL;
  assign col_need  = col_keep + (l_r.cfg2[sbba_pkg::CFG_CRC] ?
                     sbba_pkg::PAIRS_CRC : 3'h0);

  always_comb
  begin
    l_nxt         = l_r;
    l_nxt.rst     = {l_r.rst[0], 1'b1};
    l_nxt.cfg1    = {crc_enable, fixed_chop, otf_enable, wide_mode};
    l_nxt.cfg2    = l_r.cfg1;
    l_nxt.cs_n    = cs_n;
    l_nxt.act_n   = act_n;
    l_nxt.ras_n   = ras_n;
    l_nxt.cas_n   = cas_n;
    l_nxt.we_n    = we_n;
    l_nxt.bg      = group_select_bits;
    l_nxt.ba      = bank_select_bits;
    l_nxt.a       = addr;
    l_nxt.ready   = f_in_ready;
    l_nxt.dropped = l_r.push && !f_in_ready;
    l_nxt.push    = 1'b0;
    if (col_done)
    begin
      l_nxt.push          = 1'b1;
      l_nxt.push_cmd      = l_r.pend;
      l_nxt.push_cmd.data = col_word;
    end
    else if (!col_busy && (d_act || d_rd || d_wr || d_pre))
    begin
      l_nxt.pend.op     = d_act ? sbba_pkg::SBBA_OP_ACT :
                          d_rd  ? sbba_pkg::SBBA_OP_RD  :
                          d_wr  ? sbba_pkg::SBBA_OP_WR  :
                                  sbba_pkg::SBBA_OP_PRE;
      l_nxt.pend.group  = l_r.cfg2[sbba_pkg::CFG_WIDE] ?
                          {1'b0, l_r.bg[0]} : l_r.bg;
      l_nxt.pend.bank   = l_r.ba;
      l_nxt.pend.addr   = l_r.a;
      l_nxt.pend.auto_close = l_r.a[sbba_pkg::AUTO_CLOSE_BIT];
      l_nxt.pend.chop   = w_chop;
      l_nxt.pend.data   = '0;
      l_nxt.push        = !d_wr;
      l_nxt.push_cmd    = l_nxt.pend;
    end
  end

  // link registers; commands are only seen after reset release
  always_ff @(posedge dram_clk or negedge reset_n)
  begin
    if (!reset_n)
      l_r <= '0;
    else
      l_r <= l_nxt;
  end

  sbba_beat_collect u_collect (
    .clk     (dram_clk),
    .rst_n   (lrst_n),
    .start   (col_start),
    .keep    (col_keep),
    .need    (col_need),
    .strobe  (data_strobe),
    .dq_rise (dq_rise),
    .dq_fall (dq_fall),
    .busy    (col_busy),
    .done    (col_done),
    .word    (col_word)
  );

  sbba_fifo #(
    .W (sbba_pkg::CMD_W),
    .D (sbba_pkg::FIFO_DEPTH)
  ) u_fifo (
    .w_clk     (dram_clk),
    .w_rst_n   (lrst_n),
    .in_valid  (l_r.push),
    .in_data   (l_r.push_cmd),
    .in_ready  (f_in_ready),
    .r_clk     (ref_clk),
    .r_rst_n   (crst_n),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (take)
  );

  // core side: bank state and burst storage
  assign cmd    = sbba_pkg::sbba_cmd_t'(f_out_data);
  assign take   = f_out_valid && !hold_in;
  assign idx    = {cmd.group, cmd.bank};
  assign scol   = cmd.addr[sbba_pkg::SLOT_LSB-1:0];
  assign slot   = {idx, cmd.addr[sbba_pkg::SLOT_LSB +: sbba_pkg::SLOT_W]};
  assign mem_rdata = mem[slot];
  assign mem_we = take && (cmd.op == sbba_pkg::SBBA_OP_WR)
                  && c_r.open[idx];
  // a chopped write keeps the four beats it did not carry
  assign mem_wdata = cmd.chop ?
    ((rot_l(cmd.data, scol) & rot_l({32'h0, 32'hffffffff}, scol)) |
     (mem_rdata & ~rot_l({32'h0, 32'hffffffff}, scol))) :
    rot_l(cmd.data, scol);

  always_comb
  begin
    c_nxt          = c_r;
    c_nxt.err      = 1'b0;
    c_nxt.wr_done  = 1'b0;
    c_nxt.rd_valid = 1'b0;
    if (take)
    begin
      unique case (cmd.op)
        sbba_pkg::SBBA_OP_ACT:
        begin
          c_nxt.open[idx] = 1'b1;
          c_nxt.row[idx]  = cmd.addr;
        end
        sbba_pkg::SBBA_OP_RD, sbba_pkg::SBBA_OP_WR:
        begin
          if (!c_r.open[idx])
            c_nxt.err = 1'b1;
          else
          begin
            if (cmd.auto_close)
              c_nxt.open[idx] = 1'b0;
            if (cmd.op == sbba_pkg::SBBA_OP_WR)
              c_nxt.wr_done = 1'b1;
            else
            begin
              c_nxt.rd_valid = 1'b1;
              c_nxt.rd_bank  = idx;
              c_nxt.rd_col   = cmd.addr[sbba_pkg::COL_W-1:0];
              c_nxt.rd_word  = rot_l(mem_rdata, 3'h0 - scol);
              if (cmd.chop)
                c_nxt.rd_word[sbba_pkg::CORE_W-1:32] = '0;
            end
          end
        end
        sbba_pkg::SBBA_OP_PRE:
        begin
          if (cmd.addr[sbba_pkg::AUTO_CLOSE_BIT])
            c_nxt.open = '0;
          else
            c_nxt.open[idx] = 1'b0;
        end
      endcase
    end
  end

  // core registers; reset leaves every row closed
  always_ff @(posedge ref_clk or negedge crst_n)
  begin
    if (!crst_n)
      c_r <= '0;
    else
      c_r <= c_nxt;
  end

  // burst storage write
  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      mem[slot] <= mem_wdata;
  end

  // outputs, all from flops
  assign link_ready   = l_r.ready;
  assign cmd_dropped  = l_r.dropped;
  assign open_banks   = c_r.open;
  assign access_error = c_r.err;
  assign wr_done      = c_r.wr_done;
  assign rd_valid     = c_r.rd_valid;
  assign rd_word      = c_r.rd_word;
  assign rd_bank      = c_r.rd_bank;
  assign rd_col       = c_r.rd_col;

  // checks
  sequence s_full_start;
    col_start && !w_chop && !l_r.cfg2[sbba_pkg::CFG_CRC];
  endsequence
  sequence s_four_pairs;
    data_strobe [*4];
  endsequence

  AST_FULL_BURST: assert property (
    @(posedge dram_clk) disable iff (!lrst_n)
    s_full_start ##1 s_four_pairs |=> col_done)
    else $error("full burst not complete after four pairs");

  AST_PAIR_PLACE: assert property (
    @(posedge dram_clk) disable iff (!lrst_n)
    s_full_start ##1 (data_strobe && dq_rise == 8'h5a && dq_fall == 8'ha5)
      ##1 data_strobe [*3] |=> col_word[15:0] == 16'ha55a)
    else $error("first beat pair misplaced");

  AST_X16_GROUP: assert property (
    @(posedge dram_clk) disable iff (!lrst_n)
    l_r.push && l_r.cfg2[sbba_pkg::CFG_WIDE] |-> !l_r.push_cmd.group[1])
    else $error("x16 mode used a second group bit");

  AST_OTF_CHOP: assert property (
    @(posedge dram_clk) disable iff (!lrst_n)
    col_start && l_r.cfg2[sbba_pkg::CFG_OTF]
      && !l_r.a[sbba_pkg::CHOP_SEL_BIT] |-> col_keep == 3'h2)
    else $error("select bit low did not chop");

  AST_ACT_OPENS: assert property (
    @(posedge ref_clk) disable iff (!crst_n)
    take && cmd.op == sbba_pkg::SBBA_OP_ACT |=> open_banks[$past(idx)])
    else $error("activate left bank closed");

  AST_CLOSED_ERR: assert property (
    @(posedge ref_clk) disable iff (!crst_n)
    take && cmd.op != sbba_pkg::SBBA_OP_ACT
      && cmd.op != sbba_pkg::SBBA_OP_PRE && !c_r.open[idx]
      |=> access_error && !rd_valid && !wr_done)
    else $error("access to closed bank not flagged");

  AST_AUTO_CLOSE: assert property (
    @(posedge ref_clk) disable iff (!crst_n)
    take && cmd.op == sbba_pkg::SBBA_OP_RD && c_r.open[idx]
      && cmd.auto_close |=> rd_valid && !open_banks[$past(idx)])
    else $error("auto close did not close the row");

  AST_RD_COL: assert property (
    @(posedge ref_clk) disable iff (!crst_n)
    take && cmd.op == sbba_pkg::SBBA_OP_RD && c_r.open[idx]
      |=> rd_valid && rd_col == $past(cmd.addr[9:0]))
    else $error("read column not reported");

  AST_RD_CHOP: assert property (
    @(posedge ref_clk) disable iff (!crst_n)
    take && cmd.op == sbba_pkg::SBBA_OP_RD && c_r.open[idx] && cmd.chop
      |=> rd_word[63:32] == 32'h0)
    else $error("chopped read returned upper beats");

  AST_RESET_CLOSED: assert property (
    @(posedge ref_clk) $rose(crst_n) |-> open_banks == 16'h0)
    else $error("rows open after reset");
endmodule
